// >>> pkg/qedc_params.svh
// Purpose: constants for the error-correcting bus memory slave
// Assumes: 50 MHz hclk
// Notes:   times in ns, cycle counts derived from them
`ifndef QEDC_PARAMS_SVH
`define QEDC_PARAMS_SVH

`define QE_CLK_MHZ      50
// Least times round up, longest times round down
`define QE_CEIL(ns)     ((((ns) * `QE_CLK_MHZ) + 999) / 1000)
`define QE_FLOOR(ns)    (((ns) * `QE_CLK_MHZ) / 1000)

`define QE_RD_DATA_NS   220
`define QE_ADV_NS       60
`define QE_RD_ALLOW_NS  200
`define QE_WR_ACC_NS    160
`define QE_WR_ALLOW_NS  150
`define QE_CYCLE_NS     395
`define QE_REF_INT_NS   15600

`define QE_RD_DATA_CYC  `QE_CEIL(`QE_RD_DATA_NS)
`define QE_ADV_CYC      `QE_FLOOR(`QE_ADV_NS)
`define QE_RD_ALLOW_CYC `QE_FLOOR(`QE_RD_ALLOW_NS)
`define QE_WR_ACC_CYC   `QE_CEIL(`QE_WR_ACC_NS)
`define QE_WR_ALLOW_CYC `QE_FLOOR(`QE_WR_ALLOW_NS)
`define QE_REF_BUSY_CYC `QE_CEIL(`QE_CYCLE_NS)
`define QE_REF_INT_CYC  `QE_FLOOR(`QE_REF_INT_NS)

// I/O page address of the first CSR slot
`define QE_CSR_BASE     13'h1440

// Register bus offsets
`define QE_OFS_CTRL     12'h000
`define QE_OFS_STAT     12'h004
`define QE_OFS_CSR      12'h008

// Option register fields and reset value
`define QE_CTRL_ADV     0
`define QE_CTRL_BLK     1
`define QE_CTRL_LFIRST  2
`define QE_CTRL_TRAP    3
`define QE_CTRL_XCSR    5
`define QE_CTRL_BATT    6
`define QE_CTRL_RESET   7'h10

// Bus CSR fields
`define QE_CSR_EN       0
`define QE_CSR_XSEL     2
`define QE_CSR_FLAG     15

`endif

// >>> pkg/qedc_pkg.sv
// Purpose: types for the error-correcting bus memory slave
// Assumes: nothing
// Notes:   constants live in qedc_params.svh
package qedc_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_REF,
        ST_WAIT,
        ST_RD,
        ST_WR,
        ST_HOLD,
        ST_SKIP
    } qedc_state_t;

    typedef enum logic [1:0] {
        TRAP_OFF,
        TRAP_SGL,
        TRAP_DBL,
        TRAP_BOTH
    } qedc_trap_t;

endpackage

// >>> rtl/qedc_ecc.sv
// Purpose: single-correct double-detect code for one 16-bit word
// Assumes: codeword bit 0 is overall parity, bits 21:1 Hamming positions
// Notes:   purely combinational
`timescale 1ns/100ps
module qedc_ecc
    import qedc_pkg::*;
(
    input  wire logic [15:0] wr_data,
    output logic      [21:0] wr_code,
    input  wire logic [21:0] rd_code,
    output logic      [15:0] rd_data,
    output logic             err_single,
    output logic             err_double,
    output logic      [4:0]  err_pos
);
    logic [21:0] base;
    logic [21:0] fixed;
    logic [4:0]  wsyn;
    logic [4:0]  rsyn;

    // XOR of the positions of all set bits
    function automatic logic [4:0] qedc_syndrome(input logic [21:0] cw);
        logic [4:0] s;
        s = 5'h00;
        for (int p = 1; p < 22; p++)
        begin
            if (cw[p])
                s = s ^ 5'(p);
        end
        return s;
    endfunction

    // Data sits at the non power-of-two positions
    function automatic logic [21:0] qedc_place(input logic [15:0] d);
        logic [21:0] cw;
        int          k;
        cw = 22'h00_0000;
        k  = 0;
        for (int p = 1; p < 22; p++)
        begin
            if ((p & (p - 1)) != 0)
            begin
                cw[p] = d[k];
                k     = k + 1;
            end
        end
        return cw;
    endfunction

    function automatic logic [15:0] qedc_gather(input logic [21:0] cw);
        logic [15:0] d;
        int          k;
        d = 16'h0000;
        k = 0;
        for (int p = 1; p < 22; p++)
        begin
            if ((p & (p - 1)) != 0)
            begin
                d[k] = cw[p];
                k    = k + 1;
            end
        end
        return d;
    endfunction

    // Encode: check bits make the syndrome zero
    always_comb
    begin
        base = qedc_place(wr_data);
        wsyn = qedc_syndrome(base);
        wr_code = base;
        for (int i = 0; i < 5; i++)
            wr_code[1 << i] = wsyn[i];
        wr_code[0] = ^wr_code[21:1];
    end

    // Decode: odd overall parity means one flipped bit, fixable
    always_comb
    begin
        rsyn  = qedc_syndrome(rd_code);
        fixed = rd_code;
        if ((^rd_code) && rsyn != 5'h00 && rsyn < 5'h16)
            fixed[rsyn] = ~fixed[rsyn];
        rd_data    = qedc_gather(fixed);
        err_single = ^rd_code;
        err_double = !(^rd_code) && rsyn != 5'h00;
        err_pos    = rsyn;
    end

endmodule

// >>> rtl/qedc_refresh.sv
// Purpose: distributed refresh request timer
// Assumes: the slave grants a request only between bus cycles
// Notes:   a request that arrives during the ack stays pending
`timescale 1ns/100ps
`include "qedc_params.svh"
module qedc_refresh
    import qedc_pkg::*;
#(
    parameter int INT_CYC = `QE_REF_INT_CYC
)(
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       ref_ack,
    output logic            ref_req,
    output logic      [7:0] ref_row
);
    logic [15:0] tick;

    // Interval counter; expiry sets the request, set beats the ack
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tick    <= 16'h0000;
            ref_req <= 1'b0;
            ref_row <= 8'h00;
        end
        else
        begin
            tick    <= (tick == 16'h0000) ? 16'(INT_CYC - 1) : tick - 16'h0001;
            ref_req <= (tick == 16'h0000) || (ref_req && !ref_ack);
            if (ref_ack)
                ref_row <= ref_row + 8'h01;
        end
    end

endmodule

// >>> rtl/qedc_slave.sv
// Purpose: 16-bit backplane memory slave with error correction and CSR
// Assumes: backplane pins arrive synchronous to hclk, active high here
// Notes:   options sit in an AHB-Lite register, address straps are pins
//
// The register offsets and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
`include "qedc_params.svh"
module qedc_slave
    import qedc_pkg::*;
#(
    parameter int MEM_AW  = 20,
    parameter int REF_INT = `QE_REF_INT_CYC
)(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    input  wire logic [21:0] q_dal_in,
    output logic      [21:0] q_dal_out,
    output logic             q_dal_oe,
    input  wire logic        q_sync,
    input  wire logic        q_din,
    input  wire logic        q_dout,
    input  wire logic        q_wtbt,
    input  wire logic        q_bs7,
    output logic             q_rply,
    input  wire logic [7:0]  start_fit,
    input  wire logic [7:0]  stop_fit,
    input  wire logic [2:0]  cap_sel,
    input  wire logic [3:0]  csr_slot,
    input  wire logic        csr_off,
    input  wire logic        on_backup,
    output logic             err_led
);
    qedc_state_t state;
    qedc_state_t next_state;
    qedc_trap_t  trap_sel;
    logic [21:0] mem [0:(1 << MEM_AW) - 1];
    logic [21:0] adr_q;
    logic [21:0] rd_q;
    logic [21:0] wr_code;
    logic [20:0] woff;
    logic [20:0] cap_mask;
    logic [MEM_AW-1:0] idx;
    logic [12:0] csr_adr;
    logic [15:0] fix_data;
    logic [15:0] merged;
    logic [15:0] wr_word;
    logic [15:0] rd_word;
    logic [15:0] csr_rd;
    logic [7:0]  win_start;
    logic [7:0]  win_stop;
    logic [7:0]  cnt_sync;
    logic [7:0]  cnt_strb;
    logic [7:0]  ref_row;
    logic [6:0]  ctrl;
    logic [6:0]  csr_adr_f;
    logic [4:0]  e_pos;
    logic [4:0]  last_pos;
    logic [4:0]  ref_cnt;
    logic [2:0]  cap_c;
    logic [11:0] ap_adr;
    logic [31:0] ahb_rd;
    logic        bs7_q, sync_q, served, last_rd, ref_adr;
    logic        csr_en, csr_xsel, csr_flag, last_sgl;
    logic        e_sgl, e_dbl, mem_hit, csr_hit, csr_on, strobe, sync_rise;
    logic        opt_adv, opt_blk, opt_lfirst, opt_xcsr, prot, trap;
    logic        rd_data_ok, rd_rply_ok, wr_ok, mem_we, err_evt, csr_wr;
    logic        bump, ref_req, ref_ack, next_rply, ap_take, ap_wr;

    // Reply is due once sync is old enough and the strobe late enough
    function automatic logic qedc_due(input logic [7:0] s, input logic [7:0] t,
                                      input logic [7:0] base, input logic [7:0] allow,
                                      input logic [7:0] lead);
        return ({1'b0, s} + {1'b0, lead} >= {1'b0, base}) &&
               ({1'b0, t} + {1'b0, allow} + {1'b0, lead} >= {1'b0, base});
    endfunction

    // Options from the register bus
    assign opt_adv    = ctrl[`QE_CTRL_ADV];
    assign opt_blk    = ctrl[`QE_CTRL_BLK];
    assign opt_lfirst = ctrl[`QE_CTRL_LFIRST];
    assign opt_xcsr   = ctrl[`QE_CTRL_XCSR];
    assign trap_sel   = qedc_trap_t'(ctrl[`QE_CTRL_TRAP +: 2]);
    assign prot       = ctrl[`QE_CTRL_BATT] && on_backup;

    // Address decode; fitted strap reads as zero
    assign win_start = ~start_fit;
    assign win_stop  = ~stop_fit;
    assign mem_hit   = !bs7_q && adr_q[21:14] >= win_start && adr_q[21:14] <= win_stop;
    assign csr_on    = !csr_off;
    assign csr_adr   = `QE_CSR_BASE + {8'h00, csr_slot, 1'b0};
    assign csr_hit   = bs7_q && csr_on && adr_q[12:0] == csr_adr;
    // Beyond the fitted size the offset wraps, no fault is raised
    assign cap_c     = (cap_sel > 3'd4) ? 3'd4 : cap_sel;
    assign cap_mask  = 21'h1F_FFFF >> (3'd5 - cap_c);
    assign woff      = {adr_q[21:14] - win_start, adr_q[13:1]};
    assign idx       = MEM_AW'(woff & cap_mask);

    // Cycle timing against sync and strobe
    assign strobe     = q_din || q_dout;
    assign sync_rise  = q_sync && !sync_q;
    assign rd_data_ok = qedc_due(cnt_sync, cnt_strb, 8'(`QE_RD_DATA_CYC),
                                 8'(`QE_RD_ALLOW_CYC), 8'h00);
    assign rd_rply_ok = qedc_due(cnt_sync, cnt_strb, 8'(`QE_RD_DATA_CYC),
                                 8'(`QE_RD_ALLOW_CYC),
                                 opt_adv ? 8'(`QE_ADV_CYC) : 8'h00);
    assign wr_ok      = qedc_due(cnt_sync, cnt_strb, 8'(`QE_WR_ACC_CYC),
                                 8'(`QE_WR_ALLOW_CYC), 8'h00);

    // Error correction on every read, no setup needed
    qedc_ecc u_ecc (
        .wr_data    (wr_word),
        .wr_code    (wr_code),
        .rd_code    (rd_q),
        .rd_data    (fix_data),
        .err_single (e_sgl),
        .err_double (e_dbl),
        .err_pos    (e_pos)
    );

    qedc_refresh #(.INT_CYC(REF_INT)) u_ref (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ref_ack (ref_ack),
        .ref_req (ref_req),
        .ref_row (ref_row)
    );

    // Byte writes merge into the corrected old word
    assign merged  = !q_wtbt ? q_dal_in[15:0] :
                     adr_q[0] ? {q_dal_in[15:8], fix_data[7:0]} :
                                {fix_data[15:8], q_dal_in[7:0]};
    assign wr_word = (state == ST_RD) ? fix_data : merged;
    assign mem_we  = mem_hit && !prot &&
                     ((state == ST_RD && rd_data_ok && e_sgl && csr_on) ||
                      (state == ST_WR && wr_ok));
    assign err_evt = state == ST_RD && rd_data_ok && mem_hit && (e_sgl || e_dbl);
    assign trap    = csr_en && ((e_sgl && (trap_sel == TRAP_SGL || trap_sel == TRAP_BOTH)) ||
                                (e_dbl && (trap_sel == TRAP_DBL || trap_sel == TRAP_BOTH)));
    assign csr_wr  = state == ST_WR && wr_ok && csr_hit;
    assign csr_rd  = (csr_xsel && opt_xcsr && last_sgl) ?
                     {csr_flag, 5'h00, last_pos, 2'b00, csr_xsel, 1'b0, csr_en} :
                     {csr_flag, 3'b000, csr_adr_f, 2'b00, csr_xsel, 1'b0, csr_en};
    assign rd_word = mem_hit ? fix_data : csr_rd;
    assign ref_ack = state == ST_IDLE && next_state == ST_REF;
    assign bump    = state == ST_WAIT && next_state == ST_WAIT && served && strobe;
    assign next_rply = q_sync && ((state == ST_RD && rd_rply_ok) ||
                                  (state == ST_WR && wr_ok) || (state == ST_HOLD && strobe));

    // Cycle sequencer
    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:
                if (sync_rise && !prot)
                    next_state = ST_WAIT;
                else if (ref_req && !q_sync)
                    next_state = ST_REF;
            ST_REF:
                if (ref_cnt == 5'h00)
                    next_state = (q_sync && ref_adr) ? ST_WAIT : ST_IDLE;
            ST_WAIT:
                if (!q_sync)
                    next_state = ST_IDLE;
                else if (prot || !(mem_hit || csr_hit))
                    next_state = ST_SKIP;
                else if (strobe)
                begin
                    if (!served)
                        next_state = q_din ? ST_RD : ST_WR;
                    else if (last_rd && q_dout)
                        next_state = ST_WR;
                    else if (!(opt_blk && last_rd == q_din))
                        next_state = ST_SKIP;
                end
            ST_RD:
                if (!q_sync)
                    next_state = ST_IDLE;
                else if (rd_data_ok)
                    next_state = ST_HOLD;
            ST_WR:
                if (!q_sync)
                    next_state = ST_IDLE;
                else if (wr_ok)
                    next_state = ST_HOLD;
            ST_HOLD:
                if (!q_sync)
                    next_state = ST_IDLE;
                else if (!strobe)
                    next_state = ST_WAIT;
            ST_SKIP:
                if (!q_sync)
                    next_state = ST_IDLE;
            default:
                next_state = ST_IDLE;
        endcase
    end

    // Sequencer state, counters and address
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state    <= ST_IDLE;
            sync_q   <= 1'b0;
            cnt_sync <= 8'h00;
            cnt_strb <= 8'h00;
            ref_cnt  <= 5'h00;
            ref_adr  <= 1'b0;
            adr_q    <= 22'h00_0000;
            bs7_q    <= 1'b0;
            served   <= 1'b0;
            last_rd  <= 1'b0;
        end
        else
        begin
            state    <= next_state;
            sync_q   <= q_sync;
            cnt_sync <= (state inside {ST_IDLE, ST_REF}) ? 8'h00 : cnt_sync + {7'h00, ~&cnt_sync};
            cnt_strb <= (state == ST_WAIT) ? 8'h00 : cnt_strb + {7'h00, ~&cnt_strb};
            ref_cnt  <= ref_ack ? 5'(`QE_REF_BUSY_CYC - 1) : ref_cnt - {4'h0, |ref_cnt};
            ref_adr  <= (state == ST_REF) && (ref_adr || sync_rise);
            if (sync_rise && (state == ST_IDLE || state == ST_REF))
            begin
                adr_q <= q_dal_in;
                bs7_q <= q_bs7;
            end
            else if (bump)
                adr_q <= adr_q + 22'h00_0002;
            if (state == ST_IDLE || bump || state == ST_RD || state == ST_WR)
                served <= 1'b0;
            else if (state == ST_HOLD)
                served <= 1'b1;
            if (state == ST_WAIT && next_state == ST_RD)
                last_rd <= 1'b1;
            else if (state == ST_WAIT && next_state == ST_WR)
                last_rd <= 1'b0;
        end
    end

    // Backplane drivers; only enables, never a driven high
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            q_rply    <= 1'b0;
            q_dal_out <= 22'h00_0000;
            q_dal_oe  <= 1'b0;
        end
        else
        begin
            q_rply <= next_rply;
            if (state == ST_RD && rd_data_ok && q_sync)
            begin
                q_dal_out <= {4'h0, trap, trap, rd_word};
                q_dal_oe  <= 1'b1;
            end
            else if (!next_rply)
                q_dal_oe <= 1'b0;
        end
    end

    // Array write and read; contents are not reset
    always_ff @(posedge hclk)
    begin
        if (mem_we)
            mem[idx] <= wr_code;
        rd_q <= mem[idx];
    end

    // CSR and error capture; a capture overrides a write in the same cycle
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            csr_en    <= 1'b0;
            csr_xsel  <= 1'b0;
            csr_flag  <= 1'b0;
            csr_adr_f <= 7'h00;
            last_pos  <= 5'h00;
            last_sgl  <= 1'b0;
            err_led   <= 1'b0;
        end
        else
        begin
            if (csr_wr && (!q_wtbt || !adr_q[0]))
            begin
                csr_en   <= q_dal_in[`QE_CSR_EN];
                csr_xsel <= q_dal_in[`QE_CSR_XSEL];
            end
            if (csr_wr && (!q_wtbt || adr_q[0]))
                csr_flag <= q_dal_in[`QE_CSR_FLAG];
            if (err_evt && !(opt_lfirst && csr_flag))
            begin
                csr_flag  <= 1'b1;
                csr_adr_f <= adr_q[21:15];
                last_pos  <= e_pos;
                last_sgl  <= e_sgl;
            end
            if (err_evt)
                err_led <= 1'b1;
        end
    end

    // AHB-Lite slave, zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign ap_take   = hsel && htrans[1] && hready;
    assign ahb_rd    = (haddr[11:0] == `QE_OFS_CTRL) ? {25'h000_0000, ctrl} :
                       (haddr[11:0] == `QE_OFS_STAT) ?
                       {16'h0000, ref_row, 4'h0, err_led, csr_flag, last_sgl, prot} :
                       (haddr[11:0] == `QE_OFS_CSR) ? {16'h0000, csr_rd} : 32'h0000_0000;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ap_wr  <= 1'b0;
            ap_adr <= 12'h000;
            hrdata <= 32'h0000_0000;
            ctrl   <= `QE_CTRL_RESET;
        end
        else
        begin
            ap_wr  <= ap_take && hwrite;
            ap_adr <= haddr[11:0];
            if (ap_take && !hwrite)
                hrdata <= ahb_rd;
            if (ap_wr && ap_adr == `QE_OFS_CTRL)
                ctrl <= hwdata[6:0];
        end
    end

endmodule

// >>> verification/qedc_slave_asserts.sv
// Purpose: port-level checks on the bus memory slave
// Assumes: one clock domain, hresetn active low
// Notes:   bound into every qedc_slave
`timescale 1ns/100ps
module qedc_slave_asserts
    import qedc_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hreadyout,
    input  wire logic        hresp,
    input  wire logic [21:0] q_dal_in,
    input  wire logic [21:0] q_dal_out,
    input  wire logic        q_dal_oe,
    input  wire logic        q_sync,
    input  wire logic        q_din,
    input  wire logic        q_dout,
    input  wire logic        q_bs7,
    input  wire logic        q_rply,
    input  wire logic [7:0]  start_fit,
    input  wire logic [7:0]  stop_fit,
    input  wire logic        err_led
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // Window limits in 16K blocks; a fitted strap reads as 0
    wire logic [7:0] lo_blk = ~start_fit;
    wire logic [7:0] hi_blk = ~stop_fit;

    // Memory cycle whose address falls outside the window
    sequence miss_start;
        $rose(q_sync) && !q_bs7 && (q_dal_in[21:14] < lo_blk || q_dal_in[21:14] > hi_blk);
    endsequence
    sequence strobe_off;
        !q_din && !q_dout;
    endsequence

    miss_quiet_a: assert property (miss_start |=> !q_rply throughout (##[0:80] !q_sync))
        else $error("reply outside the address window");
    sync_drop_a: assert property (!q_sync |=> !q_rply)
        else $error("reply without sync");
    drive_rply_a: assert property (q_dal_oe |-> q_rply && !q_dout)
        else $error("data lines driven outside a read reply");
    top_lines_a: assert property (q_dal_oe |-> q_dal_out[21:18] == 4'h0)
        else $error("upper lines driven");
    min_access_a: assert property ($rose(q_sync) |=> !q_rply [*7])
        else $error("reply earlier than the access time");
    rply_release_a: assert property (q_rply ##0 strobe_off |-> ##[1:2] !q_rply)
        else $error("reply held after strobe removed");
    led_sticky_a: assert property (err_led |=> err_led)
        else $error("error indicator cleared");
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("register bus not ready or not okay");
endmodule

bind qedc_slave qedc_slave_asserts qedc_slave_asserts_i (
    .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
    .q_dal_in(q_dal_in), .q_dal_out(q_dal_out), .q_dal_oe(q_dal_oe), .q_sync(q_sync),
    .q_din(q_din), .q_dout(q_dout), .q_bs7(q_bs7), .q_rply(q_rply),
    .start_fit(start_fit), .stop_fit(stop_fit), .err_led(err_led)
);

// >>> verification/qedc_master.sv
// Purpose: backplane master model, one memory or CSR cycle per call
// Assumes: lines pulled up, so a released line reads as logical 0
// Notes:   reply and data times counted from the edge sync is first seen
`timescale 1ns/100ps
module qedc_master (
    input  wire logic        hclk,
    input  wire logic [21:0] dal,
    input  wire logic        q_rply,
    input  wire logic        q_dal_oe,
    output logic      [21:0] m_dal,
    output logic             q_sync,
    output logic             q_din,
    output logic             q_dout,
    output logic             q_wtbt,
    output logic             q_bs7
);
    initial {m_dal, q_sync, q_din, q_dout, q_wtbt, q_bs7} = '0;

    // Miss gives tr = -1; strobe held until reply, and until data on reads
    task automatic cyc(input logic wr, input logic bt, input logic io, input logic [21:0] adr,
                       input logic [15:0] wd, input int lag,
                       output logic [15:0] rd, output int tr, output int td);
        int n;
        begin
            tr = -1;
            td = -1;
            rd = 16'h0000;
            n = 0;
            m_dal <= adr;
            q_bs7 <= io;
            @(posedge hclk);
            q_sync <= 1'b1;
            @(posedge hclk);
            m_dal <= 22'h0;
            repeat (lag) @(posedge hclk);
            q_din <= !wr;
            q_dout <= wr;
            q_wtbt <= bt;
            if (wr)
                m_dal <= {6'h00, wd};
            while (n < 60 && (wr ? tr < 0 : td < 0))
            begin
                @(posedge hclk);
                n++;
                if (q_rply && tr < 0)
                    tr = lag + n;
                if (q_dal_oe && td < 0)
                begin
                    td = lag + n;
                    rd = dal[15:0];
                end
            end
            {q_din, q_dout, q_wtbt} <= 3'b000;
            m_dal <= 22'h0;
            n = 0;
            do @(posedge hclk); while (q_rply && ++n < 10);
            q_sync <= 1'b0;
            q_bs7 <= 1'b0;
            @(posedge hclk);
        end
    endtask
endmodule

// >>> verification/testbench.sv
// Purpose: self-checking bench for the bus memory slave
// Assumes: hreadyout is the bus hready; refresh kept out of timed cycles
// Notes:   window is 16K blocks 1..2, CSR slot 3
`timescale 1ns/100ps
module testbench
    import qedc_pkg::*;
;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic        csr_off = 1'b0, on_backup = 1'b0;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, r;
    logic [1:0]  htrans = 2'b00;
    logic [2:0]  hsize = 3'h2, cap_sel = 3'h4;
    logic [7:0]  start_fit = 8'hfe, stop_fit = 8'hfd;
    logic [3:0]  csr_slot = 4'h3;
    logic        hready, hresp, q_dal_oe, q_sync, q_din, q_dout, q_wtbt, q_bs7, q_rply, err_led;
    logic [21:0] q_dal_out, m_dal;
    logic [15:0] d;
    wire  logic [21:0] dal;
    int          fails = 0, total_checks = 0, t1, t2, tw0, tr0;
    logic [21:0] miss_adr [2] = '{22'h00_3ffe, 22'h00_c000};

    always #10 hclk = ~hclk;
    // Open collector: a line is asserted if either side pulls it
    assign dal = m_dal | (q_dal_oe ? q_dal_out : 22'h0);

    qedc_slave #(.MEM_AW(10), .REF_INT(20000)) qedc_slave_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .q_dal_in(dal),
        .q_dal_out(q_dal_out), .q_dal_oe(q_dal_oe), .q_sync(q_sync), .q_din(q_din),
        .q_dout(q_dout), .q_wtbt(q_wtbt), .q_bs7(q_bs7), .q_rply(q_rply),
        .start_fit(start_fit), .stop_fit(stop_fit), .cap_sel(cap_sel), .csr_slot(csr_slot),
        .csr_off(csr_off), .on_backup(on_backup), .err_led(err_led)
    );
    qedc_master qedc_master_i (
        .hclk(hclk), .dal(dal), .q_rply(q_rply), .q_dal_oe(q_dal_oe), .m_dal(m_dal),
        .q_sync(q_sync), .q_din(q_din), .q_dout(q_dout), .q_wtbt(q_wtbt), .q_bs7(q_bs7)
    );

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Hold each phase until hready is sampled high, bounded
    task automatic wait_rdy();
        int n;
        begin
            n = 0;
            do @(posedge hclk); while (hready !== 1'b1 && ++n < 20);
            if (n >= 20)
            begin
                fails++;
                close_out();
            end
        end
    endtask

    task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {20'h0_0000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy();
        r = hrdata;
    endtask

    task automatic bp(input logic wr, input logic bt, input logic io, input logic [21:0] a,
                      input logic [15:0] wd, input int lag);
        qedc_master_i.cyc(wr, bt, io, a, wd, lag, d, t1, t2);
    endtask

    initial
    begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (30) @(posedge hclk);
        ahb(1'b0, 12'h000, 0);
        chk("ctrl reset", 32'h0000_0010, r);
        ahb(1'b0, 12'h00c, 0);
        chk("unmapped", 32'h0000_0000, r);
        bp(1'b1, 1'b0, 1'b0, 22'h00_4000, 16'h5a5a, 0);
        tw0 = t1;
        bp(1'b0, 1'b0, 1'b0, 22'h00_4000, 0, 0);
        tr0 = t1;
        chk("rd start", 16'h5a5a, d);
        chk("lead off", 0, 32'(t2 - t1));
        bp(1'b1, 1'b0, 1'b0, 22'h00_bffe, 16'h1111, 0);
        bp(1'b0, 1'b0, 1'b0, 22'h00_bffe, 0, 0);
        chk("rd stop", 16'h1111, d);
        foreach (miss_adr[i])
        begin
            bp(1'b0, 1'b0, 1'b0, miss_adr[i], 0, 0);
            chk("miss", 32'hffff_ffff, 32'(t1));
        end
        bp(1'b1, 1'b0, 1'b0, 22'h00_4002, 16'h2222, 12);
        chk("wr delay", 6, 32'(t1 - tw0));
        bp(1'b0, 1'b0, 1'b0, 22'h00_4002, 0, 14);
        chk("rd delay", 5, 32'(t1 - tr0));
        bp(1'b1, 1'b0, 1'b0, 22'h00_4010, 16'h1234, 0);
        bp(1'b1, 1'b1, 1'b0, 22'h00_4011, 16'hab00, 0);
        bp(1'b0, 1'b0, 1'b0, 22'h00_4010, 0, 0);
        chk("byte write", 16'hab34, d);
        ahb(1'b1, 12'h000, 32'h0000_0011);
        bp(1'b0, 1'b0, 1'b0, 22'h00_4000, 0, 0);
        chk("lead on", 3, 32'(t2 - t1));
        chk("adv access", 32'(tw0), 32'(t1));
        bp(1'b1, 1'b0, 1'b1, 22'h00_1446, 16'h0001, 0);
        ahb(1'b0, 12'h008, 0);
        chk("csr", 32'h0000_0001, r);
        bp(1'b0, 1'b0, 1'b1, 22'h00_1444, 0, 0);
        chk("csr other", 32'hffff_ffff, 32'(t1));
        csr_off <= 1'b1;
        bp(1'b0, 1'b0, 1'b1, 22'h00_1446, 0, 0);
        chk("csr off", 32'hffff_ffff, 32'(t1));
        ahb(1'b1, 12'h000, 32'h0000_0050);
        on_backup <= 1'b1;
        bp(1'b1, 1'b0, 1'b0, 22'h00_4000, 16'h0f0f, 0);
        chk("protect", 32'hffff_ffff, 32'(t1));
        ahb(1'b0, 12'h004, 0);
        chk("protect flag", 1, {31'h0, r[0]});
        on_backup <= 1'b0;
        bp(1'b0, 1'b0, 1'b0, 22'h00_4000, 0, 0);
        chk("kept", 16'h5a5a, d);
        chk("led", 0, {31'h0, err_led});
        close_out();
    end

    // Watchdog against a hang anywhere
    initial
    begin
        repeat (100000) @(posedge hclk);
        fails++;
        close_out();
    end
endmodule
